// >>> pkg/ddcr_cfg.svh
// offsets, field positions, reset values and counts of the channel code registers
`ifndef DDCR_CFG_SVH
`define DDCR_CFG_SVH
`define DDCR_OFS_CFG 8'h03
`define DDCR_OFS_GAIN 8'h04
`define DDCR_OFS_CODE_A 8'h08
`define DDCR_OFS_CODE_B 8'h09
`define DDCR_RST_ZERO 16'h0000
`define DDCR_RST_MID 16'h8000
`define DDCR_RST_CFG 16'h0000
`define DDCR_RST_GAIN 16'h0000
`define DDCR_CFG_REF_OFF_BIT 8
`define DDCR_GAIN_HALVER_BIT 8
`define DDCR_GAIN_B_BIT 1
`define DDCR_GAIN_A_BIT 0
`define DDCR_SPI_FRAME_BITS 5'd24
`define DDCR_I2C_BASE 5'h12
`define DDCR_I2C_BYTE_BITS 4'd8
`define DDCR_CODE_BITS 16
`define DDCR_SYNC_W 10
`define DDCR_IX_IFSEL 0
`define DDCR_IX_PUL 1
`define DDCR_IX_HEAD 2
`define DDCR_IX_SCLK 3
`define DDCR_IX_SYNCN 4
`define DDCR_IX_SDIN 5
`define DDCR_IX_SCL 6
`define DDCR_IX_SDA 7
`define DDCR_IX_ASEL0 8
`endif

// >>> pkg/ddcr_pkg.sv
// types shared by the channel code register block
package ddcr_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
    } ddcr_wr_t;
    typedef enum logic [2:0] {
        I2_IDLE,
        I2_ADDR,
        I2_CMD,
        I2_MSB,
        I2_LSB
    } ddcr_i2c_st_t;
endpackage

// >>> src/ddcr_core.sv
// serial register front end and channel code registers of a dual converter
// Overview of operation
// R1: channel A code register at 8h, resets 0000h or 8000h by level select pin
// R2: channel B code register at 9h, same reset choice as channel A
// R3: codes are unsigned straight binary, msb aligned; 16-bit uses all bits
// R4: 14-bit uses bits 15..2, 12-bit uses bits 15..4
// R5: strap low selects 3-wire spi, high selects i2c
// R6: at power-up both channels take the known code set by level select pin
// R7: spi is mode cpol 0 cpha 1 with 24-bit write frames
// R8: host drives frame select low around each whole packet
// R9: with external reference host disables internal one first
// R10: host order: reference off, divider, gain, then channel codes
// R11: writing 0100h to offset 03h turns the internal reference off
// R12: writing 0103h to offset 04h sets divider on and gain two on both
// R13: outputs stay disabled on short headroom until divider is enabled
// R14: i2c slave address comes from address select pins, four choices
// R15: host never applies external reference with internal reference on
// R16: spi frame is 8-bit address then 16 data bits, msb first
`include "ddcr_cfg.svh"
module ddcr_core #(
    parameter int RES = 16
) (
    input logic clk_i,
    input logic rst_i,
    input logic interface_select_pin_i,
    input logic power_up_level_select_i,
    input logic [1:0] bus_address_select_i,
    input logic headroom_short_i,
    input logic sclk_i,
    input logic sync_n_i,
    input logic sdin_i,
    input logic scl_i,
    input logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic [RES-1:0] code_a_o,
    output logic [RES-1:0] code_b_o,
    output logic internal_ref_en_o,
    output logic reference_halver_o,
    output logic [1:0] gain_x2_o,
    output logic out_en_o,
    output ddcr_pkg::ddcr_wr_t wr_o,
    output logic wr_vld_o
);
    import ddcr_pkg::*;

    function automatic logic wr_hit(input ddcr_wr_t w, input logic [7:0] ofs);
        wr_hit = (w.addr == ofs);
    endfunction

    // pins pass two flops; stage one feeds stage two only
    logic [`DDCR_SYNC_W-1:0] pin_w;
    logic [`DDCR_SYNC_W-1:0] s1_ff;
    logic [`DDCR_SYNC_W-1:0] s2_ff;
    assign pin_w = {bus_address_select_i, sda_i, scl_i, sdin_i, sync_n_i, sclk_i,
                    headroom_short_i, power_up_level_select_i, interface_select_pin_i};
    genvar gi;
    generate
        for (gi = 0; gi < `DDCR_SYNC_W; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                s1_ff[gi] <= pin_w[gi];
                s2_ff[gi] <= s1_ff[gi];
            end
        end
    endgenerate

    wire pul_s = s2_ff[`DDCR_IX_PUL];
    wire head_s = s2_ff[`DDCR_IX_HEAD];
    wire sclk_s = s2_ff[`DDCR_IX_SCLK];
    wire syncn_s = s2_ff[`DDCR_IX_SYNCN];
    wire sdin_s = s2_ff[`DDCR_IX_SDIN];
    wire scl_s = s2_ff[`DDCR_IX_SCL];
    wire sda_s = s2_ff[`DDCR_IX_SDA];
    wire [1:0] asel_s = s2_ff[`DDCR_IX_ASEL0+1:`DDCR_IX_ASEL0];

    // straps are caught while reset is held, so hold reset past the sync delay
    logic iface_i2c_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            iface_i2c_ff <= s2_ff[`DDCR_IX_IFSEL]; // [R5]
        end
    end

    // edge history of the sampled link pins
    logic sclk_q_ff;
    logic syncn_q_ff;
    logic scl_q_ff;
    logic sda_q_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_q_ff <= 1'b0;
            syncn_q_ff <= 1'b1;
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            sclk_q_ff <= sclk_s;
            syncn_q_ff <= syncn_s;
            scl_q_ff <= scl_s;
            sda_q_ff <= sda_s;
        end
    end

    // spi: data is stable at the falling clock edge in mode 1
    wire sclk_fall = sclk_q_ff & ~sclk_s; // [R7]
    wire sync_edge = syncn_q_ff ^ syncn_s;
    wire sync_rise = ~syncn_q_ff & syncn_s; // [R8]
    logic [4:0] spi_cnt_ff;
    logic [23:0] spi_sh_ff;
    logic [4:0] nxt_spi_cnt;
    assign nxt_spi_cnt = (spi_cnt_ff == `DDCR_SPI_FRAME_BITS) ? spi_cnt_ff
                                                              : spi_cnt_ff + 5'd1;
    always_ff @(posedge clk_i) begin
        if (rst_i || sync_edge) begin
            spi_cnt_ff <= 5'd0;
        end else if (!syncn_s && sclk_fall) begin
            spi_cnt_ff <= nxt_spi_cnt;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spi_sh_ff <= 24'h000000;
        end else if (!syncn_s && sclk_fall && spi_cnt_ff != `DDCR_SPI_FRAME_BITS) begin
            spi_sh_ff <= {spi_sh_ff[22:0], sdin_s}; // [R16]
        end
    end
    // a short frame is dropped rather than half applied; a long one is applied with its first 24 bits
    wire spi_commit = sync_rise && !iface_i2c_ff
                      && spi_cnt_ff == `DDCR_SPI_FRAME_BITS; // [R7]

    // i2c write-only slave: address, pointer, data msb, data lsb
    wire scl_rise = ~scl_q_ff & scl_s;
    wire scl_fall = scl_q_ff & ~scl_s;
    wire i2_start = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
    wire i2_stop = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
    ddcr_i2c_st_t i2_st_ff;
    logic [3:0] i2_cnt_ff;
    logic [7:0] i2_sh_ff;
    logic [7:0] i2_ptr_ff;
    logic [7:0] i2_msb_ff;
    logic i2_ack_ff;
    wire [6:0] my_addr = {`DDCR_I2C_BASE, asel_s}; // [R14]
    wire byte_done = scl_fall && !i2_ack_ff && i2_cnt_ff == `DDCR_I2C_BYTE_BITS;
    wire addr_match = i2_sh_ff[7:1] == my_addr && !i2_sh_ff[0]; // [R14]
    wire i2_commit = byte_done && i2_st_ff == I2_LSB;

    always_ff @(posedge clk_i) begin
        if (rst_i || !iface_i2c_ff || i2_stop) begin
            i2_st_ff <= I2_IDLE;
            i2_cnt_ff <= 4'd0;
            i2_ack_ff <= 1'b0;
        end else if (i2_start) begin
            i2_st_ff <= I2_ADDR;
            i2_cnt_ff <= 4'd0;
            i2_ack_ff <= 1'b0;
        end else if (i2_st_ff != I2_IDLE) begin
            if (scl_rise && !i2_ack_ff && i2_cnt_ff != `DDCR_I2C_BYTE_BITS) begin
                i2_cnt_ff <= i2_cnt_ff + 4'd1;
            end
            if (scl_fall && i2_ack_ff) begin
                i2_ack_ff <= 1'b0;
                i2_cnt_ff <= 4'd0;
            end
            if (byte_done) begin
                unique case (i2_st_ff)
                    I2_ADDR: begin
                        i2_ack_ff <= addr_match; // [R14]
                        i2_st_ff <= addr_match ? I2_CMD : I2_IDLE;
                    end
                    I2_CMD: begin
                        i2_ack_ff <= 1'b1;
                        i2_st_ff <= I2_MSB;
                    end
                    I2_MSB: begin
                        i2_ack_ff <= 1'b1;
                        i2_st_ff <= I2_LSB;
                    end
                    I2_LSB: begin
                        i2_ack_ff <= 1'b1;
                        i2_st_ff <= I2_MSB;
                    end
                    default: i2_st_ff <= I2_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            i2_sh_ff <= 8'h00;
            i2_ptr_ff <= 8'h00;
            i2_msb_ff <= 8'h00;
        end else begin
            if (scl_rise && !i2_ack_ff && i2_cnt_ff != `DDCR_I2C_BYTE_BITS) begin
                i2_sh_ff <= {i2_sh_ff[6:0], sda_s};
            end
            if (byte_done && i2_st_ff == I2_CMD) begin
                i2_ptr_ff <= i2_sh_ff;
            end
            if (byte_done && i2_st_ff == I2_MSB) begin
                i2_msb_ff <= i2_sh_ff;
            end
        end
    end
    assign sda_o = 1'b0;
    assign sda_oe_o = i2_ack_ff;

    // one write path, fed by whichever port the strap chose
    wire wr_vld = spi_commit | i2_commit; // [R5]
    ddcr_wr_t wr_w;
    assign wr_w = iface_i2c_ff ? {i2_ptr_ff, i2_msb_ff, i2_sh_ff} : spi_sh_ff;

    logic [15:0] cfg_ff;
    logic [15:0] gain_ff;
    logic [15:0] code_a_ff;
    logic [15:0] code_b_ff;
    logic [15:0] rst_code;
    assign rst_code = pul_s ? `DDCR_RST_MID : `DDCR_RST_ZERO; // [R6]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_ff <= `DDCR_RST_CFG;
            gain_ff <= `DDCR_RST_GAIN;
            code_a_ff <= rst_code; // [R1]
            code_b_ff <= rst_code; // [R2]
        end else if (wr_vld) begin
            if (wr_hit(wr_w, `DDCR_OFS_CFG)) cfg_ff <= wr_w.data; // [R11]
            if (wr_hit(wr_w, `DDCR_OFS_GAIN)) gain_ff <= wr_w.data; // [R12]
            if (wr_hit(wr_w, `DDCR_OFS_CODE_A)) code_a_ff <= wr_w.data; // [R1]
            if (wr_hit(wr_w, `DDCR_OFS_CODE_B)) code_b_ff <= wr_w.data; // [R2]
        end
    end

    // low bits of shorter variants are don't-care and simply dropped
    assign code_a_o = code_a_ff[`DDCR_CODE_BITS-1 -: RES]; // [R3] [R4]
    assign code_b_o = code_b_ff[`DDCR_CODE_BITS-1 -: RES]; // [R3] [R4]
    assign internal_ref_en_o = ~cfg_ff[`DDCR_CFG_REF_OFF_BIT]; // [R11]
    assign reference_halver_o = gain_ff[`DDCR_GAIN_HALVER_BIT]; // [R12]
    assign gain_x2_o = {gain_ff[`DDCR_GAIN_B_BIT], gain_ff[`DDCR_GAIN_A_BIT]};

    logic out_en_ff;
    logic wr_vld_ff;
    ddcr_wr_t wr_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_en_ff <= 1'b0;
            wr_vld_ff <= 1'b0;
            wr_ff <= '0;
        end else begin
            out_en_ff <= ~(head_s & ~gain_ff[`DDCR_GAIN_HALVER_BIT]); // [R13]
            wr_vld_ff <= wr_vld;
            if (wr_vld) begin
                wr_ff <= wr_w;
            end
        end
    end
    assign out_en_o = out_en_ff;
    assign wr_vld_o = wr_vld_ff;
    assign wr_o = wr_ff;

    property p_rst_a;
        // sync stages carry no pin value during the first reset edges
        @(posedge clk_i) rst_i && $past(rst_i, 3)
        |=> code_a_ff == ($past(pul_s) ? 16'h8000 : 16'h0000);
    endproperty
    a_rst_a: assert property (p_rst_a) else $error("code a reset value wrong"); // [R1]

    property p_rst_b;
        @(posedge clk_i) rst_i ##1 !rst_i |-> code_b_ff == code_a_ff;
    endproperty
    a_rst_b: assert property (p_rst_b) else $error("code b reset differs"); // [R2]

    property p_wr_a;
        @(posedge clk_i) disable iff (rst_i)
        wr_vld && wr_w.addr == 8'h08 |=> code_a_o == $past(wr_w.data[15 -: RES]);
    endproperty
    a_wr_a: assert property (p_wr_a) else $error("code a output not updated"); // [R4]

    property p_wr_b;
        @(posedge clk_i) disable iff (rst_i)
        wr_vld && wr_w.addr == 8'h09 |=> code_b_ff == $past(wr_w.data);
    endproperty
    a_wr_b: assert property (p_wr_b) else $error("code b not written"); // [R2]

    property p_spi_len;
        @(posedge clk_i) disable iff (rst_i)
        spi_commit |-> $past(spi_cnt_ff) == 5'd24 && !syncn_q_ff;
    endproperty
    a_spi_len: assert property (p_spi_len) else $error("spi commit without 24 bits"); // [R7]

    property p_port_sel;
        @(posedge clk_i) disable iff (rst_i)
        (spi_commit -> !iface_i2c_ff) && (sda_oe_o -> iface_i2c_ff);
    endproperty
    a_port_sel: assert property (p_port_sel) else $error("wrong port active"); // [R5]

    property p_ref_off;
        @(posedge clk_i) disable iff (rst_i)
        wr_vld && wr_w.addr == 8'h03 && wr_w.data == 16'h0100 |=> !internal_ref_en_o;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("reference still on"); // [R11]

    property p_gain;
        @(posedge clk_i) disable iff (rst_i)
        wr_vld && wr_w.addr == 8'h04 && wr_w.data == 16'h0103
        |=> reference_halver_o && gain_x2_o == 2'b11;
    endproperty
    a_gain: assert property (p_gain) else $error("divider or gain not set"); // [R12]

    property p_headroom;
        @(posedge clk_i) disable iff (rst_i)
        (head_s && !gain_ff[8])[*2] |-> !out_en_o;
    endproperty
    a_headroom: assert property (p_headroom) else $error("output enabled without headroom"); // [R13]

    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        $rose(sda_oe_o) |-> $past(i2_st_ff) != I2_IDLE && $past(i2_cnt_ff) == 4'd8;
    endproperty
    a_ack: assert property (p_ack) else $error("ack outside ninth bit"); // [R14]
endmodule // ddcr_core

// >>> testbench/ddcr_host.sv
// host processor model acting as spi and i2c master of the code register block
`include "ddcr_cfg.svh"
module ddcr_host (
    input wire logic clk_i,
    input wire logic sda_line_i,
    output logic sclk_o,
    output logic sync_n_o,
    output logic sdin_o,
    output logic scl_o,
    output logic sda_low_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ack_ok;
    // idle levels: spi clock low, select high, i2c lines released
    initial begin
        sclk_o = 1'b0;
        sync_n_o = 1'b1;
        sdin_o = 1'b1;
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        ack_ok = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // address byte first, then data, msb first
    task automatic spi_write(input logic [7:0] addr, input logic [15:0] data, input int nbits);
        logic [23:0] frame;
        frame = {addr, data};
        sync_n_o = 1'b0; // one select low around the whole packet
        tick(4);
        for (int i = 0; i < nbits; i++) begin
            sclk_o = 1'b1; // idle low, data moves on rise, taken on fall
            sdin_o = frame[23 - i];
            tick(8);
            sclk_o = 1'b0;
            tick(8);
        end
        sync_n_o = 1'b1;
        sdin_o = ~sdin_o; // a released line must not keep showing the last bit
        tick(6);
    endtask
    task automatic i2c_bit(input logic b);
        sda_low_o = ~b;
        tick(4);
        scl_o = 1'b1;
        tick(8);
        scl_o = 1'b0;
        tick(4);
    endtask
    task automatic i2c_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            i2c_bit(b[7 - i]);
        end
        sda_low_o = 1'b0;
        tick(4);
        scl_o = 1'b1;
        tick(4);
        ack_ok = ack_ok & ~sda_line_i;
        tick(4);
        scl_o = 1'b0;
        tick(4);
    endtask
    // callers only write channel code B here, with no earlier reference off,
    // divider or gain write over i2c
    task automatic i2c_write(input logic [1:0] sel, input logic [7:0] ptr, input logic [15:0] data);
        ack_ok = 1'b1;
        sda_low_o = 1'b1;
        tick(8);
        scl_o = 1'b0;
        tick(4);
        i2c_byte({`DDCR_I2C_BASE, sel, 1'b0});
        i2c_byte(ptr);
        i2c_byte(data[15:8]);
        i2c_byte(data[7:0]);
        sda_low_o = 1'b1;
        tick(4);
        scl_o = 1'b1;
        tick(8);
        sda_low_o = 1'b0;
        tick(8);
    endtask
endmodule // ddcr_host

// >>> testbench/testbench.sv
// self-checking bench of the channel code register block
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin bad_count++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import ddcr_pkg::*;
    logic clk, rst, ifsel, pul, head;
    logic [1:0] asel;
    logic sclk, sync_n, sdin, scl, sda_low, sda_o, sda_oe, ref_en, halver, out_en, wr_vld;
    logic [15:0] code_a, code_b;
    logic [13:0] code_a14, code_b14;
    logic [1:0] gain;
    ddcr_wr_t wr;
    wire sda_line = ~(sda_low | sda_oe); // pulled up unless someone pulls low
    int bad_count = 0;
    int comparisons = 0;
    int wr_seen = 0;
    int exp_wr = 0;
    ddcr_core #(.RES(16)) ddcr_core_inst (.clk_i(clk), .rst_i(rst),
        .interface_select_pin_i(ifsel), .power_up_level_select_i(pul),
        .bus_address_select_i(asel), .headroom_short_i(head), .sclk_i(sclk),
        .sync_n_i(sync_n), .sdin_i(sdin), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .code_a_o(code_a), .code_b_o(code_b), .internal_ref_en_o(ref_en),
        .reference_halver_o(halver), .gain_x2_o(gain), .out_en_o(out_en), .wr_o(wr),
        .wr_vld_o(wr_vld));
    ddcr_core #(.RES(14)) ddcr_core_res14_inst (.clk_i(clk), .rst_i(rst),
        .interface_select_pin_i(ifsel), .power_up_level_select_i(pul),
        .bus_address_select_i(asel), .headroom_short_i(head), .sclk_i(sclk),
        .sync_n_i(sync_n), .sdin_i(sdin), .scl_i(scl), .sda_i(sda_line), .sda_o(),
        .sda_oe_o(), .code_a_o(code_a14), .code_b_o(code_b14), .internal_ref_en_o(),
        .reference_halver_o(), .gain_x2_o(), .out_en_o(), .wr_o(), .wr_vld_o());
    ddcr_host ddcr_host_inst (.clk_i(clk), .sda_line_i(sda_line), .sclk_o(sclk),
        .sync_n_o(sync_n), .sdin_o(sdin), .scl_o(scl), .sda_low_o(sda_low));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wr_vld === 1'b1) wr_seen++;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic do_reset(input logic f, input logic p, input logic [1:0] a);
        @(posedge clk);
        #1;
        rst = 1'b1;
        ifsel = f;
        pul = p;
        asel = a;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        ddcr_host_inst.tick(2);
    endtask
    // applied writes pulse the monitor once; dropped ones leave the count alone
    task automatic wait_wr(input int inc);
        exp_wr = exp_wr + inc;
        for (int n = 0; n < 40 && (inc == 0 || wr_seen < exp_wr); n++) @(posedge clk);
        #1;
        `CHK("write count", exp_wr, wr_seen)
    endtask
    initial begin
        {rst, ifsel, pul, asel} = 5'h10;
        head = 1'b1;
        do_reset(1'b0, 1'b0, 2'h0);
        `CHK("code_a zero reset", 16'h0000, code_a)
        `CHK("code_b zero reset", 16'h0000, code_b)
        `CHK("ref on at reset", 1'b1, ref_en)
        `CHK("outputs off", 1'b0, out_en)
        `CHK("sda drive level", 1'b0, sda_o)
        ddcr_host_inst.spi_write(8'h03, 16'h0100, 24);
        wait_wr(1);
        `CHK("ref off", 1'b0, ref_en)
        `CHK("outputs still off", 1'b0, out_en)
        ddcr_host_inst.spi_write(8'h04, 16'h0103, 24);
        wait_wr(1);
        `CHK("halver", 1'b1, halver)
        `CHK("gain", 2'h3, gain)
        `CHK("outputs on", 1'b1, out_en)
        ddcr_host_inst.spi_write(8'h08, 16'h7fff, 24);
        wait_wr(1);
        `CHK("code_a", 16'h7fff, code_a)
        `CHK("code_a 14 bit", 14'h1fff, code_a14)
        `CHK("write record", {8'h08, 16'h7fff}, wr)
        ddcr_host_inst.spi_write(8'h09, 16'hffff, 24);
        wait_wr(1);
        `CHK("code_b", 16'hffff, code_b)
        ddcr_host_inst.spi_write(8'h08, 16'h1234, 23);
        wait_wr(0);
        `CHK("short frame dropped", 16'h7fff, code_a)
        $display("test spi done");
        do_reset(1'b0, 1'b1, 2'h0);
        `CHK("code_a mid reset", 16'h8000, code_a)
        `CHK("code_b mid reset", 16'h8000, code_b)
        `CHK("code_b 14 bit mid", 14'h2000, code_b14)
        $display("test reset level done");
        do_reset(1'b1, 1'b1, 2'h1);
        ddcr_host_inst.spi_write(8'h08, 16'h1111, 24);
        wait_wr(0);
        `CHK("spi ignored in i2c", 16'h8000, code_a)
        ddcr_host_inst.i2c_write(2'h1, 8'h09, 16'habcd);
        wait_wr(1);
        `CHK("i2c ack", 1'b1, ddcr_host_inst.ack_ok)
        `CHK("i2c code_b", 16'habcd, code_b)
        `CHK("i2c code_b 14 bit", 14'h2af3, code_b14)
        ddcr_host_inst.i2c_write(2'h2, 8'h09, 16'h5555);
        wait_wr(0);
        `CHK("other address no ack", 1'b0, ddcr_host_inst.ack_ok)
        `CHK("other address no write", 16'habcd, code_b)
        $display("test i2c done");
        end_of_test();
    end
    // the whole run needs well under 100 us; a hang is cut at 500 us
    initial begin
        #500000;
        bad_count++;
        end_of_test();
    end
endmodule // testbench
